// ### output_unit_status_handshake.sv
// Purpose: device end of the word-mapped controller exchange
// Assumes: controller words are synchronous to clk
// Notes: status word is re-registered, so flags show one cycle late
//
// Behaviour
// - read cycle loads RAM word at the pointer into read_result_word
// - invalid data sets status bit 03, valid write clears it
// - conversion error sets bit 04, data discarded, valid write clears
// - bit 05 shows speed mode, set means normal speed
// - bit 06 set after consuming controller write and command words
// - bit 07 set after read data is placed
// - bit 08 set while out of limits, in-range write clears it
// - bit 09 follows external supply detection
// - bit 10 set when a handshake sequence ends abnormally
// - bit 10 cleared by any change of host_consumed_bit
// - read and write requests ignored while bit 10 is set
// - bit 11 toggles at 1 Hz with 50 percent duty
// - heartbeat paused during nonvolatile memory write
// - bit 12 set on diagnosis pass, cleared on internal fault
`timescale 1ns/1ps
module output_unit_status_handshake
  import unit_status_pkg::*;
#(
  parameter longint PULSE_HALF = PULSE_HALF_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // controller output words
  input wire logic [15:0] write_data_word,
  input wire logic [15:0] command_word,
  // analog core status
  input wire logic data_invalid,
  input wire logic conv_error,
  input wire logic limit_over,
  input wire logic speed_normal,
  input wire logic ext_supply_on,
  input wire logic nvm_busy,
  input wire logic diag_pass,
  input wire logic diag_fault,
  // controller input words
  output logic [15:0] read_result_word,
  output logic [15:0] unit_status_word
);
  // ==========================================================
  // decoding
  // bcd pointer to ram index; out-of-range gives all ones
  function automatic logic [5:0] ptr_index(input logic [7:0] bcd);
    logic [6:0] val;
    val = 7'(bcd[7:4]) * 7'h0A + 7'(bcd[3:0]);
    if (bcd[7:4] > 4'h9 || bcd[3:0] > 4'h9 || val > 7'(RAM_LAST))
      ptr_index = 6'h3F;
    else
      ptr_index = val[5:0];
  endfunction : ptr_index

  // ==========================================================
  // storage and flags
  logic [15:0] ram [RAM_DEPTH];
  logic posted_q;
  logic consumed_q;
  logic read_done;
  logic write_done;
  logic load_pending;
  logic invalid_flag;
  logic conv_flag;
  logic limit_flag;
  logic seq_err;
  logic health;
  logic pulse;
  logic posted_rise;
  logic posted_fall;
  logic consumed_rise;
  logic consumed_edge;
  logic take;
  logic is_write;
  logic [5:0] idx;
  logic ptr_ok;
  logic good_write;

  assign posted_rise = command_word[CMD_POSTED_BIT] & ~posted_q;
  assign posted_fall = ~command_word[CMD_POSTED_BIT] & posted_q;
  assign consumed_edge = command_word[CMD_CONSUMED_BIT] ^ consumed_q;
  assign consumed_rise = command_word[CMD_CONSUMED_BIT] & ~consumed_q;
  // only a posted edge starts a transfer; no request while in error
  assign take = posted_rise & ~seq_err;
  assign is_write = command_word[CMD_DIR_BIT];
  assign idx = ptr_index(command_word[15:CMD_PTR_LSB]);
  assign ptr_ok = (idx != 6'h3F);
  assign good_write = take & is_write & ptr_ok & ~data_invalid & ~conv_error;

  // ==========================================================
  // edge history of the command bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      posted_q <= 1'b0;
      consumed_q <= 1'b0;
    end else begin
      posted_q <= command_word[CMD_POSTED_BIT];
      consumed_q <= command_word[CMD_CONSUMED_BIT];
    end
  end

  // ram write; erroneous data never lands so old setup stays
  always_ff @(posedge clk) begin
    if (good_write)
      ram[idx] <= write_data_word;
  end

  // read path; result word loaded one cycle ahead of its flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_result_word <= READ_RESET;
      load_pending <= 1'b0;
    end else begin
      load_pending <= 1'b0;
      if (take && !is_write && ptr_ok) begin
        read_result_word <= ram[idx];
        load_pending <= 1'b1;
      end
    end
  end

  // handshake completion flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_done <= 1'b0;
      write_done <= 1'b0;
    end else begin
      if (take)
        read_done <= 1'b1;
      else if (posted_fall)
        read_done <= 1'b0;
      if (load_pending)
        write_done <= 1'b1;
      else if (consumed_rise)
        write_done <= 1'b0;
    end
  end

  // sequence error: consumed raised with nothing to consume,
  // or posted dropped before the words were taken
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      seq_err <= 1'b0;
    else if ((consumed_rise && !write_done && !load_pending && !seq_err) ||
             (posted_fall && !read_done))
      seq_err <= 1'b1;
    else if (consumed_edge)
      seq_err <= 1'b0;
  end

  // data quality flags; a new error wins over a clearing write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      invalid_flag <= 1'b0;
      conv_flag <= 1'b0;
      limit_flag <= 1'b0;
    end else begin
      if (take && is_write && (data_invalid || !ptr_ok))
        invalid_flag <= 1'b1;
      else if (good_write)
        invalid_flag <= 1'b0;
      if (conv_error)
        conv_flag <= 1'b1;
      else if (good_write)
        conv_flag <= 1'b0;
      if (limit_over)
        limit_flag <= 1'b1;
      else if (good_write)
        limit_flag <= 1'b0;
    end
  end

  // self-diagnosis result; a fault outranks a pass
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      health <= 1'b0;
    else if (diag_fault)
      health <= 1'b0;
    else if (diag_pass)
      health <= 1'b1;
  end

  // heartbeat source
  pulse_flag_gen #(
    .HALF_CYCLES(int'(PULSE_HALF))
  ) u_pulse (
    .clk(clk),
    .reset_n(reset_n),
    .hold(nvm_busy),
    .pulse(pulse)
  );

  // ==========================================================
  // status word register, reserved bits held at zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      unit_status_word <= STATUS_RESET;
    else begin
      unit_status_word <= STATUS_RESET;
      unit_status_word[ST_INVALID] <= invalid_flag;
      unit_status_word[ST_CONV_ERR] <= conv_flag;
      unit_status_word[ST_SPEED] <= speed_normal;
      unit_status_word[ST_READ_DONE] <= read_done;
      unit_status_word[ST_WRITE_DONE] <= write_done;
      unit_status_word[ST_LIMIT] <= limit_flag;
      unit_status_word[ST_SUPPLY] <= ext_supply_on;
      unit_status_word[ST_SEQ_ERR] <= seq_err;
      unit_status_word[ST_PULSE] <= pulse;
      unit_status_word[ST_HEALTH] <= health;
    end
  end
endmodule : output_unit_status_handshake

// ### unit_status_pkg.sv
// Purpose: shared constants for the output unit status handshake
// Assumes: 200 MHz module clock
// Notes: bit positions are those of the exchanged I/O words
package unit_status_pkg;
  // ==========================================================
  // word layout
  localparam int WORD_W = 16;
  localparam int RAM_DEPTH = 62;
  localparam int RAM_AW = 6;
  localparam logic [5:0] RAM_LAST = 6'h3D;
  localparam logic [3:0] READ_RESULT_OFFSET = 4'h2;
  localparam logic [3:0] UNIT_STATUS_OFFSET = 4'h3;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] READ_RESET = 16'h0000;
  // ==========================================================
  // command word fields
  localparam int CMD_DIR_BIT = 0;
  localparam int CMD_POSTED_BIT = 6;
  localparam int CMD_CONSUMED_BIT = 7;
  localparam int CMD_PTR_LSB = 8;
  // ==========================================================
  // status word fields
  localparam int ST_INVALID = 3;
  localparam int ST_CONV_ERR = 4;
  localparam int ST_SPEED = 5;
  localparam int ST_READ_DONE = 6;
  localparam int ST_WRITE_DONE = 7;
  localparam int ST_LIMIT = 8;
  localparam int ST_SUPPLY = 9;
  localparam int ST_SEQ_ERR = 10;
  localparam int ST_PULSE = 11;
  localparam int ST_HEALTH = 12;
  // ==========================================================
  // timing
  localparam longint CLK_HZ = 200000000;
  localparam longint PULSE_HALF_MS = 500;
  localparam longint PULSE_HALF_CYCLES = CLK_HZ * PULSE_HALF_MS / 1000;
endpackage : unit_status_pkg

// ### pulse_flag_gen.sv
// Purpose: heartbeat square wave for the status word
// Assumes: half_cycles of at least 2
// Notes: the count freezes while hold is high, so a pause shifts phase
`timescale 1ns/1ps
module pulse_flag_gen #(
  parameter int HALF_CYCLES = 100000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic hold,
  // output
  output logic pulse
);
  // ==========================================================
  // half period counter
  logic [31:0] count;

  // toggle every half period, freeze during nonvolatile writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 32'h00000000;
      pulse <= 1'b0;
    end else if (!hold) begin
      if (count == 32'(HALF_CYCLES - 1)) begin
        count <= 32'h00000000;
        pulse <= ~pulse;
      end else begin
        count <= count + 32'h00000001;
      end
    end
  end
endmodule : pulse_flag_gen

// ### ous_asserts.sv
// Purpose: port checks for the status handshake
// Assumes: one clock, reset_n low resets all registers but the ram
// Notes: flags lag their cause by the status register
`timescale 1ns/1ps
module ous_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // watched ports
  input wire logic [15:0] command_word,
  input wire logic speed_normal,
  input wire logic conv_error,
  input wire logic nvm_busy,
  input wire logic diag_fault,
  input wire logic [15:0] unit_status_word
);
  // ========
  // aliases and handshake steps
  wire [15:0] cw = command_word;
  wire [15:0] st = unit_status_word;
  wire ptr_ok = cw[11:8] < 4'hA && cw[15:8] < 8'h62;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a take only counts once the error flag is seen clear
  sequence take;
    $rose(cw[6]) ##1 !st[10];
  endsequence
  sequence rd_take;
    ($rose(cw[6]) && !cw[0] && ptr_ok) ##1 !st[10];
  endsequence
  a_reserved_zero: assert property ((st & 16'hE007) == 16'h0000)
    else $error("reserved status bits set");
  a_speed_shown: assert property (
    $stable(speed_normal)[*2] |-> st[5] == speed_normal)
    else $error("speed flag wrong");
  a_conv_shown: assert property (conv_error[*3] |-> st[4])
    else $error("conversion flag missing");
  a_fault_clears: assert property (diag_fault[*3] |-> !st[12])
    else $error("health flag kept on fault");
  a_pulse_frozen: assert property (nvm_busy[*4] |-> $stable(st[11]))
    else $error("heartbeat moved while busy");
  a_take_flag: assert property (take |-> ##1 st[6])
    else $error("read done flag late");
  a_read_flag: assert property (rd_take |-> ##2 st[7])
    else $error("write done flag late");
  a_refuse_busy: assert property (st[10][*3] |-> !$rose(st[6]))
    else $error("request taken in error");
  a_seq_set: assert property (
    $rose(cw[7]) ##1 (!st[7] && !st[10]) |-> ##1 st[10])
    else $error("sequence error not flagged");
  a_seq_clear: assert property (
    $fell(cw[7]) && $stable(cw[6]) |-> ##2 !st[10])
    else $error("sequence error not cleared");
endmodule : ous_asserts
bind output_unit_status_handshake ous_asserts u_chk (
  .clk(clk), .reset_n(reset_n), .command_word(command_word),
  .speed_normal(speed_normal), .conv_error(conv_error),
  .nvm_busy(nvm_busy), .diag_fault(diag_fault),
  .unit_status_word(unit_status_word));

// ### host_model.sv
// Purpose: controller side of the word exchange
// Assumes: drives its words at the falling edge
// Notes: waits are bounded, ok reports a timeout
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk,
  // device words
  input wire logic [15:0] read_result_word,
  input wire logic [15:0] unit_status_word,
  // controller words
  output logic [15:0] write_data_word,
  output logic [15:0] command_word
);
  // ========
  // start idle with both handshake bits low
  initial begin
    write_data_word = 16'h0000;
    command_word = 16'h0000;
  end
  task automatic wait_bit(input int b, input logic v, output logic ok);
    ok = 1'b0;
    repeat (40) begin
      @(negedge clk);
      ok = unit_status_word[b] === v;
      if (ok) break;
    end
  endtask : wait_bit
  // bit 7 is kept so a pending error is not cleared by accident
  task automatic xfer(input logic wr, input logic [7:0] p,
      input logic [15:0] wd, output logic [15:0] rd, output logic ok);
    logic k;
    rd = 16'h0000;
    @(negedge clk);
    write_data_word = wd;
    command_word = {p, command_word[7], 6'h00, wr};
    @(negedge clk);
    command_word[6] = 1'b1;
    wait_bit(6, 1'b1, ok);
    command_word[6] = 1'b0;
    wait_bit(6, 1'b0, k);
    write_data_word = ~wd; // released word no longer shows data
    if (ok && !wr) begin
      wait_bit(7, 1'b1, ok);
      rd = read_result_word;
      command_word[7] = 1'b1;
      wait_bit(7, 1'b0, k);
      command_word[7] = 1'b0;
    end
  endtask : xfer
  task automatic flip7();
    @(negedge clk);
    command_word[7] = ~command_word[7];
  endtask : flip7
endmodule : host_model

// ### tb.sv
// Purpose: directed test of the status handshake
// Assumes: heartbeat half period cut to 10 cycles
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
module tb;
  logic clk, reset_n, data_invalid, conv_error, limit_over, ok;
  logic speed_normal, ext_supply_on, nvm_busy, diag_pass, diag_fault;
  logic [15:0] write_data_word, command_word, read_result_word;
  logic [15:0] unit_status_word, rd;
  logic [7:0] ptrs [3] = '{8'h00, 8'h09, 8'h61};
  int num_errors = 0;
  int n_tests = 0;
  int last;
  // ========
  // clock, design and controller
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  output_unit_status_handshake #(.PULSE_HALF(10)) DUT (
    .clk(clk), .reset_n(reset_n), .write_data_word(write_data_word),
    .command_word(command_word), .data_invalid(data_invalid),
    .conv_error(conv_error), .limit_over(limit_over),
    .speed_normal(speed_normal), .ext_supply_on(ext_supply_on),
    .nvm_busy(nvm_busy), .diag_pass(diag_pass), .diag_fault(diag_fault),
    .read_result_word(read_result_word),
    .unit_status_word(unit_status_word));
  host_model ctl (.clk(clk), .read_result_word(read_result_word),
    .unit_status_word(unit_status_word),
    .write_data_word(write_data_word), .command_word(command_word));
  // ========
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // status needs settling time, so look three cycles on
  task automatic flag(input int b, input logic v);
    repeat (3) @(negedge clk);
    chk({15'h0000, unit_status_word[b]}, {15'h0000, v});
  endtask : flag
  task automatic rw(input logic w, input logic [7:0] p,
      input logic [15:0] d, input logic e);
    ctl.xfer(w, p, d, rd, ok);
    chk({15'h0000, ok}, {15'h0000, e});
  endtask : rw
  task automatic tick(output int n);
    logic v;
    v = unit_status_word[11];
    for (n = 1; n < 30; n++) begin
      @(negedge clk);
      if (unit_status_word[11] !== v) break;
    end
  endtask : tick
  task automatic results;
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  // ========
  // main sequence
  initial begin
    reset_n = 1'b0;
    {data_invalid, conv_error, limit_over, nvm_busy, diag_fault} = 5'h00;
    {speed_normal, ext_supply_on, diag_pass} = 3'h7;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(unit_status_word & 16'hF7FF, 16'h1220);
    foreach (ptrs[i]) rw(1'b1, ptrs[i], 16'hA5C0 + 16'(i), 1'b1);
    foreach (ptrs[i]) begin
      rw(1'b0, ptrs[i], 16'h0000, 1'b1);
      chk(rd, 16'hA5C0 + 16'(i));
    end
    data_invalid = 1'b1;
    rw(1'b1, 8'h09, 16'h1111, 1'b1);
    data_invalid = 1'b0;
    flag(3, 1'b1);
    rw(1'b1, 8'h1A, 16'h2222, 1'b1);
    rw(1'b0, 8'h09, 16'h0000, 1'b1);
    chk(rd, 16'hA5C1);
    conv_error = 1'b1;
    limit_over = 1'b1;
    flag(4, 1'b1);
    flag(8, 1'b1);
    rw(1'b1, 8'h00, 16'h4444, 1'b1);
    {conv_error, limit_over} = 2'h0;
    rw(1'b0, 8'h00, 16'h0000, 1'b1);
    chk(rd, 16'hA5C0);
    rw(1'b1, 8'h61, 16'h5555, 1'b1);
    chk(unit_status_word & 16'h0118, 16'h0000);
    ctl.flip7();
    flag(10, 1'b1);
    rw(1'b0, 8'h61, 16'h0000, 1'b0);
    ctl.flip7();
    flag(10, 1'b0);
    rw(1'b0, 8'h61, 16'h0000, 1'b1);
    chk(rd, 16'h5555);
    tick(last);
    tick(last);
    chk(16'(last), 16'h000A);
    // the opposite half must match for an even duty cycle
    tick(last);
    chk(16'(last), 16'h000A);
    nvm_busy = 1'b1;
    repeat (3) @(negedge clk);
    tick(last);
    chk(16'(last), 16'h001E);
    nvm_busy = 1'b0;
    tick(last);
    chk({15'h0000, last < 11}, 16'h0001);
    {speed_normal, ext_supply_on, diag_fault} = 3'h1;
    repeat (3) @(negedge clk);
    chk(unit_status_word & 16'h1220, 16'h0000);
    results();
  end
endmodule : tb
